// ==== hw/tx_double_port.sv ====
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
//Function
//- Double write enqueues low then high frame
//- Receive-enable flag turns receiver on after frame
//- Disable flag clears transmitter after frame
//- Break flag sends frame as break
//- Float flag floats output after frame
//- Unblock flag clears receiver block after frame
//- Fields write-only, reset zero
//- Enabled transmitter starts buffered frame promptly
//- Single 8-bit write clears ninth bit, flags
module tx_double_port #(
    parameter int DEPTH      = 4,
    parameter int BIT_CYCLES = tx_double_pkg::BIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rdata,
    output logic             tx_out,
    output logic             tx_out_en,
    output logic             transmitter_on,
    output logic             transmit_output_float,
    output logic             receiver_block,
    output logic             rx_enable
);
    localparam int AW = $clog2(DEPTH);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } tx_state_t;

    tx_state_t                state_reg;
    tx_state_t                state_next;
    tx_double_pkg::tx_entry_t cur_reg;
    logic [15:0]              baud_reg;
    logic [3:0]               bit_reg;
    logic [10:0]              shift_reg;
    logic [31:0]              rdata_reg;
    logic                     tx_reg;
    logic                     on_reg;
    logic                     float_reg;
    logic                     block_reg;
    logic                     rxen_reg;
    logic                     en_reg;

    // Decoding
    wire wr_ext    = wr_en && (addr == tx_double_pkg::OFF_DOUBLE_EXTENDED);
    wire wr_plain  = wr_en && (addr == tx_double_pkg::OFF_DOUBLE_PLAIN);
    wire wr_single = wr_en && (addr == tx_double_pkg::OFF_SINGLE_PLAIN);
    wire wr_ctl    = wr_en && (addr == tx_double_pkg::OFF_CONTROL);
    wire rd_stat   = rd_en && (addr == tx_double_pkg::OFF_STATUS);
    wire rd_ctl    = rd_en && (addr == tx_double_pkg::OFF_CONTROL);

    function automatic tx_double_pkg::tx_entry_t ext_entry(input logic [31:0] w, input int dl, input int fl);
        tx_double_pkg::tx_entry_t e;
        e.data  = w[dl +: tx_double_pkg::EXT_DATA_W];
        e.flags = w[fl +: tx_double_pkg::FLAG_W];
        return e;
    endfunction

    function automatic tx_double_pkg::tx_entry_t plain_entry(input logic [31:0] w, input int dl);
        tx_double_pkg::tx_entry_t e;
        e.data  = {1'b0, w[dl +: tx_double_pkg::PLAIN_DATA_W]};
        e.flags = '0;
        return e;
    endfunction

    tx_double_pkg::tx_entry_t entry_a;
    tx_double_pkg::tx_entry_t entry_b;
    tx_double_pkg::tx_entry_t head;
    logic                     not_empty;
    logic [AW:0]              level;

    // Frame order: first field into slot a, second into slot b
    assign entry_a = wr_ext   ? ext_entry(wdata, tx_double_pkg::FIRST_DATA_LSB, tx_double_pkg::FIRST_FLAG_LSB)
                   : wr_plain ? plain_entry(wdata, tx_double_pkg::PLAIN_FIRST_LSB)
                   : plain_entry(wdata, tx_double_pkg::PLAIN_FIRST_LSB);
    assign entry_b = wr_ext ? ext_entry(wdata, tx_double_pkg::SECOND_DATA_LSB, tx_double_pkg::SECOND_FLAG_LSB)
                   : plain_entry(wdata, tx_double_pkg::PLAIN_SECOND_LSB);

    // Room check would be software's job; frames beyond the free slots are dropped
    wire [AW:0] free   = (AW+1)'(DEPTH) - level;
    wire        push_a = (wr_ext || wr_plain || wr_single) && (free != '0);
    wire        push_b = (wr_ext || wr_plain) && (free > (AW+1)'(1));

    wire start = (state_reg == ST_IDLE) && not_empty && on_reg;
    wire bit_end  = (baud_reg == 16'(BIT_CYCLES - 1));
    wire last_bit = bit_end && (bit_reg == 4'(tx_double_pkg::FRAME_BITS - 1));

    tx_entry_fifo #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .push_a    (push_a),
        .entry_a   (entry_a),
        .push_b    (push_b),
        .entry_b   (entry_b),
        .pop       (start),
        .head      (head),
        .not_empty (not_empty),
        .level     (level)
    );

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (start) state_next = ST_SHIFT;
            ST_SHIFT: if (last_bit) state_next = ST_DONE;
            ST_DONE:  state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    // Break frame drives the line low through stop bit
    wire [10:0] frame_bits = head.flags.send_as_break ? 11'h000
                           : {1'b1, head.data, 1'b0};
    wire        done = (state_reg == ST_DONE);
    wire [31:0] status_word = {{(31-AW-1){1'b0}}, level, state_reg != ST_IDLE};
    wire [31:0] ctl_word = {28'h0000000, rxen_reg, block_reg, float_reg, on_reg};
    wire [31:0] rdata_next = rd_stat ? status_word : rd_ctl ? ctl_word : 32'h00000000;

    // Start bit on launch, then whatever sits behind the shifter
    wire tx_next = (state_next != ST_SHIFT) ? 1'b1
                 : start   ? frame_bits[0]
                 : bit_end ? shift_reg[1]
                 : shift_reg[0];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cur_reg   <= '0;
            baud_reg  <= '0;
            bit_reg   <= '0;
            shift_reg <= 11'h7ff;
        end
        else
        begin
            state_reg <= state_next;
            if (start)
            begin
                cur_reg   <= head;
                shift_reg <= frame_bits;
                baud_reg  <= '0;
                bit_reg   <= '0;
            end
            else if (state_reg == ST_SHIFT)
            begin
                baud_reg <= bit_end ? 16'h0000 : baud_reg + 16'h0001;
                if (bit_end)
                begin
                    bit_reg   <= bit_reg + 4'h1;
                    shift_reg <= {1'b1, shift_reg[10:1]};
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_reg    <= 1'b1;
            rdata_reg <= '0;
        end
        else
        begin
            tx_reg    <= tx_next;
            rdata_reg <= rdata_next;
        end
    end

    // After-frame actions; software write loses to same-cycle frame action
    wire on_next    = (done && cur_reg.flags.tx_disable_after) ? 1'b0
                    : wr_ctl ? wdata[tx_double_pkg::CTL_TX_ON_BIT] : on_reg;
    wire float_next = (done && cur_reg.flags.float_after) ? 1'b1
                    : wr_ctl ? wdata[tx_double_pkg::CTL_FLOAT_BIT] : float_reg;
    wire block_next = (done && cur_reg.flags.unblock_rx_after) ? 1'b0
                    : wr_ctl ? wdata[tx_double_pkg::CTL_RX_BLOCK_BIT] : block_reg;
    wire rxen_next  = (done && cur_reg.flags.rx_enable_after) ? 1'b1
                    : wr_ctl ? wdata[tx_double_pkg::CTL_RX_ON_BIT] : rxen_reg;

    // Enable built from next levels so the registered pin never lags the controls
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            on_reg    <= tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_TX_ON_BIT];
            float_reg <= tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_FLOAT_BIT];
            block_reg <= tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_RX_BLOCK_BIT];
            rxen_reg  <= tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_RX_ON_BIT];
            en_reg    <= tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_TX_ON_BIT]
                         && !tx_double_pkg::CTL_RESET[tx_double_pkg::CTL_FLOAT_BIT];
        end
        else
        begin
            on_reg    <= on_next;
            float_reg <= float_next;
            block_reg <= block_next;
            rxen_reg  <= rxen_next;
            en_reg    <= on_next && !float_next;
        end
    end

    // Line released when transmitter off or floated
    assign tx_out                = tx_reg;
    assign tx_out_en             = en_reg;
    assign transmitter_on        = on_reg;
    assign transmit_output_float = float_reg;
    assign receiver_block        = block_reg;
    assign rx_enable             = rxen_reg;
    assign rdata                 = rdata_reg;
endmodule
`default_nettype wire

// ==== hw/tx_double_pkg.sv ====
package tx_double_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_SINGLE_PLAIN    = 8'h34;
    localparam logic [7:0] OFF_DOUBLE_EXTENDED = 8'h38;
    localparam logic [7:0] OFF_DOUBLE_PLAIN    = 8'h3c;
    localparam logic [7:0] OFF_STATUS          = 8'h44;
    localparam logic [7:0] OFF_CONTROL         = 8'h48;

    // Extended double field positions
    localparam int SECOND_DATA_LSB = 16;
    localparam int FIRST_DATA_LSB  = 0;
    localparam int SECOND_FLAG_LSB = 27;
    localparam int FIRST_FLAG_LSB  = 11;
    localparam int EXT_DATA_W      = 9;
    localparam int FLAG_W          = 5;
    // Plain double field positions
    localparam int PLAIN_SECOND_LSB = 8;
    localparam int PLAIN_FIRST_LSB  = 0;
    localparam int PLAIN_DATA_W     = 8;

    // Control register bit positions
    localparam int CTL_TX_ON_BIT    = 0;
    localparam int CTL_FLOAT_BIT    = 1;
    localparam int CTL_RX_BLOCK_BIT = 2;
    localparam int CTL_RX_ON_BIT    = 3;

    localparam logic [8:0] DATA_RESET = 9'h000;
    localparam logic [3:0] CTL_RESET  = 4'h0;

    // Bit time in clock cycles for the shifter
    localparam int BIT_TIME_NS     = 1000;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int FRAME_BITS      = 11;

    // Per-frame action flags, bit order matches the register layout
    typedef struct packed {
        logic rx_enable_after;
        logic tx_disable_after;
        logic send_as_break;
        logic float_after;
        logic unblock_rx_after;
    } frame_flags_t;

    typedef struct packed {
        frame_flags_t flags;
        logic [8:0]   data;
    } tx_entry_t;

endpackage

// ==== hw/tx_entry_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_entry_fifo #(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  push_a,
    input  wire tx_double_pkg::tx_entry_t entry_a,
    input  wire logic                  push_b,
    input  wire tx_double_pkg::tx_entry_t entry_b,
    input  wire logic                  pop,
    output tx_double_pkg::tx_entry_t   head,
    output logic                       not_empty,
    output logic [AW:0]                level
);
    tx_double_pkg::tx_entry_t mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire  [AW:0]   n_in  = {{AW{1'b0}}, push_a} + {{AW{1'b0}}, push_b};
    wire  [AW:0]   n_out = {{AW{1'b0}}, pop & (cnt_reg != '0)};
    wire  [AW-1:0] wr_plus1 = wr_reg + 1'b1;

    assign head      = mem[rd_reg];
    assign not_empty = (cnt_reg != '0);
    assign level     = cnt_reg;

    // Entry a always lands before entry b, preserving frame order
    always_ff @(posedge clk)
    begin
        if (push_a)
            mem[wr_reg] <= entry_a;
        if (push_b)
            mem[push_a ? wr_plus1 : wr_reg] <= entry_b;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_reg + n_in[AW-1:0];
            rd_reg  <= rd_reg + n_out[AW-1:0];
            cnt_reg <= cnt_reg + n_in - n_out;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tx_double_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_double_chk #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        tx_out,
    input wire logic        tx_out_en,
    input wire logic        transmitter_on,
    input wire logic        transmit_output_float,
    input wire logic        receiver_block,
    input wire logic        rx_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A busy shifter never idles high this long
    localparam int IDLE_RUN = 10 * BIT_CYCLES + 2;
    logic [15:0] high_cnt;
    wire logic   ctl_wr = wr_en && addr == tx_double_pkg::OFF_CONTROL;
    wire logic   wo_rd = rd_en && (addr == tx_double_pkg::OFF_DOUBLE_PLAIN || addr == tx_double_pkg::OFF_DOUBLE_EXTENDED);
    always_ff @(posedge clk)
    begin
        if (!rst_n || !tx_out)
            high_cnt <= 16'h0000;
        else if (high_cnt != 16'hffff)
            high_cnt <= high_cnt + 16'h0001;
    end
    rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("rdata not zero outside a read");
    wo_read_a: assert property ($past(wo_rd) |-> rdata == 32'h0)
        else $error("write-only register read back nonzero");
    reset_state_a: assert property ($rose(rst_n) |-> tx_out && !transmitter_on && !rx_enable)
        else $error("outputs not at reset state");
    out_enable_a: assert property (tx_out_en == (transmitter_on && !transmit_output_float))
        else $error("output enable wrong");
    start_prompt_a: assert property (wr_en && addr == tx_double_pkg::OFF_DOUBLE_PLAIN && transmitter_on
        && high_cnt > IDLE_RUN |-> ##[1:3] !tx_out) else $error("frame did not start");
    hold_off_a: assert property (!transmitter_on && tx_out |=> tx_out)
        else $error("line moved while transmitter off");
    rx_on_a: assert property ($changed(rx_enable) && !$past(ctl_wr) |-> rx_enable)
        else $error("receive enable cleared by a frame");
    tx_off_a: assert property ($changed(transmitter_on) && !$past(ctl_wr) |-> !transmitter_on)
        else $error("transmitter set by a frame");
    float_a: assert property ($changed(transmit_output_float) && !$past(ctl_wr) |-> transmit_output_float)
        else $error("float cleared by a frame");
    unblock_a: assert property ($changed(receiver_block) && !$past(ctl_wr) |-> !receiver_block)
        else $error("receiver block set by a frame");
endmodule
`default_nettype wire

// ==== verification/serial_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model #(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic       clk,
    input  wire logic       line,
    output var logic [8:0]  last_data,
    output var logic        last_break,
    output var logic [7:0]  frame_count
);
    initial
    begin
        last_data = 9'h000;
        last_break = 1'b0;
        frame_count = 8'h00;
        forever
        begin
            @(negedge clk);
            if (line === 1'b0)
            begin
                // Sample mid-bit, away from the line's edges
                repeat (BIT_CYCLES / 2) @(negedge clk);
                for (int i = 0; i < 9; i++)
                begin
                    repeat (BIT_CYCLES) @(negedge clk);
                    last_data[i] = line;
                end
                repeat (BIT_CYCLES) @(negedge clk);
                last_break = !line && last_data == 9'h000;
                frame_count = frame_count + 8'h01;
                // No wait for idle: a break may run straight into the next start
                repeat (BIT_CYCLES / 2) @(negedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BC = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] rdata;
    logic        tx_out, tx_out_en, tx_on, tx_float, rx_block, rx_on, rx_break;
    logic [8:0]  rx_data;
    logic [7:0]  rx_count;
    int          mismatches = 0;
    int          compares = 0;
    // Pulled-up line: a released output reads high
    wire logic   line = tx_out_en ? tx_out : 1'b1;
    always #5 clk = ~clk;
    tx_double_port #(.DEPTH(4), .BIT_CYCLES(BC)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_out(tx_out), .tx_out_en(tx_out_en), .transmitter_on(tx_on),
        .transmit_output_float(tx_float), .receiver_block(rx_block), .rx_enable(rx_on));
    serial_rx_model #(.BIT_CYCLES(BC)) far (.clk(clk), .line(line), .last_data(rx_data), .last_break(rx_break),
        .frame_count(rx_count));
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check("rdata", exp, rdata);
    endtask
    task automatic frame(input logic [7:0] n, input logic [8:0] d, input logic brk);
        for (int i = 0; i < 2000 && rx_count !== n; i++)
            @(posedge clk);
        if (rx_count !== n)
        begin
            check("frame count", {24'h0, n}, {24'h0, rx_count});
            end_of_test();
        end
        repeat (BC) @(posedge clk);
        check("frame data", {23'h0, d}, {23'h0, rx_data});
        check("break", {31'h0, brk}, {31'h0, rx_break});
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(tx_double_pkg::OFF_CONTROL, 32'h0);
        rd(tx_double_pkg::OFF_DOUBLE_PLAIN, 32'h0);
        rd(tx_double_pkg::OFF_DOUBLE_EXTENDED, 32'h0);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
        wr(tx_double_pkg::OFF_CONTROL, 32'h5);
        repeat (50) @(posedge clk);
        wr(tx_double_pkg::OFF_DOUBLE_PLAIN, 32'h0000a55a);
        frame(8'h01, 9'h05a, 1'b0);
        frame(8'h02, 9'h0a5, 1'b0);
        rd(tx_double_pkg::OFF_CONTROL, 32'h5);
        wr(tx_double_pkg::OFF_DOUBLE_EXTENDED, {5'h12, 2'h0, 9'h12e, 5'h01, 2'h0, 9'h1c3});
        frame(8'h03, 9'h1c3, 1'b0);
        rd(tx_double_pkg::OFF_CONTROL, 32'h1);
        frame(8'h04, 9'h12e, 1'b0);
        rd(tx_double_pkg::OFF_CONTROL, 32'hb);
        check("output enable", 32'h0, {31'h0, tx_out_en});
        wr(tx_double_pkg::OFF_CONTROL, 32'h1);
        wr(tx_double_pkg::OFF_DOUBLE_EXTENDED, {5'h08, 2'h0, 9'h055, 5'h04, 2'h0, 9'h0ff});
        frame(8'h05, 9'h000, 1'b1);
        frame(8'h06, 9'h055, 1'b0);
        rd(tx_double_pkg::OFF_CONTROL, 32'h0);
        wr(tx_double_pkg::OFF_DOUBLE_PLAIN, 32'h00003c81);
        repeat (200) @(posedge clk);
        check("frame count", 32'h6, {24'h0, rx_count});
        rd(tx_double_pkg::OFF_STATUS, 32'h4);
        wr(tx_double_pkg::OFF_CONTROL, 32'h1);
        frame(8'h07, 9'h081, 1'b0);
        frame(8'h08, 9'h03c, 1'b0);
        wr(tx_double_pkg::OFF_SINGLE_PLAIN, 32'h000000ff);
        frame(8'h09, 9'h0ff, 1'b0);
        rd(tx_double_pkg::OFF_CONTROL, 32'h1);
        end_of_test();
    end
endmodule
bind tx_double_port tx_double_chk #(.BIT_CYCLES(BIT_CYCLES)) chk (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_out(tx_out), .tx_out_en(tx_out_en),
    .transmitter_on(transmitter_on), .transmit_output_float(transmit_output_float),
    .receiver_block(receiver_block), .rx_enable(rx_enable));
`default_nettype wire
